// [core/kbe_pkg.sv]
// Purpose: constants and types for the keyboard port emulation block
// Assumes: classic Wishbone slave, 32-bit data, byte address = index * 4
// Notes: port indices kept as printed, byte address derived from them
package kbe_pkg;
	// ****************************************
	// register indices and byte addresses
	// ****************************************
	localparam logic [7:0] IDX_DATA = 8'h60;
	localparam logic [7:0] IDX_SYSCTL = 8'h61;
	localparam logic [7:0] IDX_CMD = 8'h64;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h68;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h69;
	localparam logic [9:0] ADDR_DATA = {IDX_DATA, 2'h0};
	localparam logic [9:0] ADDR_SYSCTL = {IDX_SYSCTL, 2'h0};
	localparam logic [9:0] ADDR_CMD = {IDX_CMD, 2'h0};
	localparam logic [9:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'h0};
	localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};
	// ****************************************
	// commands, fields, reset values, timing
	// ****************************************
	localparam logic [7:0] CMD_WR_OUTPUT = 8'hD1;
	localparam logic [7:0] CMD_RD_OUTPUT = 8'hD0;
	localparam logic [7:0] CMD_PULSE_RST = 8'hFE;
	localparam int GATE_BIT = 1;
	localparam int RST_BIT = 0;
	localparam int CHK_CHAN_DIS_BIT = 3;
	localparam int CHK_PAR_DIS_BIT = 2;
	localparam int SPK_EN_BIT = 1;
	localparam int TMR_GATE_BIT = 0;
	localparam logic [3:0] CTL_RESET = 4'hC;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int CLK_MHZ = 40;
	localparam int RST_PULSE_NS = 200;
	localparam int RST_PULSE_CYC_I = (RST_PULSE_NS * CLK_MHZ) / 1000;
	localparam logic [3:0] RST_PULSE_CYC = 4'(RST_PULSE_CYC_I);
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_WAIT_DATA = 2'h1,
		ST_SHOW_STATUS = 2'h3
	} kbe_cmd_e;
	typedef struct packed
	{
		logic parity_err;
		logic chan_check;
		logic timer_ch2_output;
		logic refresh_toggle;
	} kbe_stat_s;
endpackage

// [core/kbe_top.sv]
// Purpose: keyboard port snoop, fast gate and warm reset, system control reg
// Assumes: one clock core_clk at 40 MHz, asynchronous active low nrst
// Notes: status pins are asynchronous and pass two flip-flops
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module kbe_top
	import kbe_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire kbe_stat_s stat_pins,
	output logic addr_line20_gate,
	output logic processor_warm_reset,
	output logic chan_check_disable,
	output logic parity_check_disable,
	output logic speaker_enable,
	output logic timer_ch2_gate,
	output logic irq
);
	// ****************************************
	// state
	// ****************************************
	logic ack_r;
	logic [31:0] dat_r;
	kbe_cmd_e st_r;
	kbe_cmd_e st_nxt;
	logic gate_r;
	logic gate_nxt;
	logic rst_r;
	logic [3:0] rst_cnt_r;
	logic [3:0] rst_cnt_nxt;
	logic [3:0] ctl_r;
	logic [7:0] data_r;
	logic [3:0] irq_stat_r;
	logic [3:0] irq_mask_r;
	kbe_stat_s stat_s1_r;
	kbe_stat_s stat_s2_r;
	kbe_stat_s stat_s3_r;

	// ****************************************
	// bus decode
	// ****************************************
	wire req = wb_cyc_i & wb_stb_i;
	wire in_range = (wb_adr_i[31:10] == 22'h0);
	wire hit_data = in_range & (wb_adr_i[9:0] == ADDR_DATA);
	wire hit_sysctl = in_range & (wb_adr_i[9:0] == ADDR_SYSCTL);
	wire hit_cmd = in_range & (wb_adr_i[9:0] == ADDR_CMD);
	wire hit_istat = in_range & (wb_adr_i[9:0] == ADDR_IRQ_STAT);
	wire hit_imask = in_range & (wb_adr_i[9:0] == ADDR_IRQ_MASK);
	wire wr_go = req & wb_we_i & ack_r & wb_sel_i[0];
	wire rd_cap = req & ~wb_we_i & ~ack_r;
	wire [7:0] wdat = wb_dat_i[7:0];
	wire wr_cmd = wr_go & hit_cmd;
	wire wr_data = wr_go & hit_data;
	wire wr_sysctl = wr_go & hit_sysctl;
	wire wr_istat = wr_go & hit_istat;
	wire wr_imask = wr_go & hit_imask;
	wire cmd_pulse = wr_cmd & (wdat == CMD_PULSE_RST);
	wire [7:0] data_rd = (st_r == ST_SHOW_STATUS)
		? {6'h00, gate_r, rst_r} : data_r;
	wire [7:0] sysctl_rd = {stat_s2_r, ctl_r};
	wire [7:0] rd_mux = hit_data ? data_rd
		: hit_sysctl ? sysctl_rd
		: hit_istat ? {4'h0, irq_stat_r}
		: hit_imask ? {4'h0, irq_mask_r}
		: 8'h00;

	// ****************************************
	// command sequencer
	// ****************************************
	always_comb
	begin
		st_nxt = st_r;
		gate_nxt = gate_r;
		if (wr_cmd)
		begin
			case (wdat)
				CMD_WR_OUTPUT: st_nxt = ST_WAIT_DATA;
				CMD_RD_OUTPUT: st_nxt = ST_SHOW_STATUS;
				default: st_nxt = ST_IDLE;
			endcase
		end
		else if (wr_data)
		begin
			case (st_r)
				ST_WAIT_DATA:
				begin
					gate_nxt = wdat[GATE_BIT];
					st_nxt = ST_IDLE;
				end
				ST_SHOW_STATUS: st_nxt = ST_SHOW_STATUS;
				default: st_nxt = ST_IDLE;
			endcase
		end
	end

	assign rst_cnt_nxt = cmd_pulse ? RST_PULSE_CYC
		: (rst_cnt_r != 4'h0) ? rst_cnt_r - 4'h1 : 4'h0;

	// ****************************************
	// interrupt events
	// ****************************************
	wire ev_par = stat_s2_r.parity_err & ~stat_s3_r.parity_err
		& ~ctl_r[CHK_PAR_DIS_BIT];
	wire ev_chan = stat_s2_r.chan_check & ~stat_s3_r.chan_check
		& ~ctl_r[CHK_CHAN_DIS_BIT];
	wire [3:0] irq_ev = {ev_chan, ev_par, gate_nxt != gate_r, cmd_pulse};
	wire [3:0] irq_clr = wr_istat ? wdat[3:0] : 4'h0;

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
			st_r <= ST_IDLE;
			gate_r <= 1'b0;
			rst_r <= 1'b0;
			rst_cnt_r <= 4'h0;
			ctl_r <= CTL_RESET;
			data_r <= DATA_RESET;
			irq_stat_r <= IRQ_RESET;
			irq_mask_r <= IRQ_RESET;
			stat_s1_r <= '0;
			stat_s2_r <= '0;
			stat_s3_r <= '0;
		end
		else
		begin
			ack_r <= req & ~ack_r;
			if (rd_cap)
				dat_r <= {24'h0, rd_mux};
			st_r <= st_nxt;
			gate_r <= gate_nxt;
			rst_cnt_r <= rst_cnt_nxt;
			rst_r <= (rst_cnt_nxt != 4'h0);
			if (wr_sysctl)
				ctl_r <= wdat[3:0];
			if (wr_data)
				data_r <= wdat;
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
			if (wr_imask)
				irq_mask_r <= wdat[3:0];
			stat_s1_r <= stat_pins;
			stat_s2_r <= stat_s1_r;
			stat_s3_r <= stat_s2_r;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign addr_line20_gate = gate_r;
	assign processor_warm_reset = rst_r;
	assign chan_check_disable = ctl_r[CHK_CHAN_DIS_BIT];
	assign parity_check_disable = ctl_r[CHK_PAR_DIS_BIT];
	assign speaker_enable = ctl_r[SPK_EN_BIT];
	assign timer_ch2_gate = ctl_r[TMR_GATE_BIT];
	assign irq = |(irq_stat_r & irq_mask_r);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_cmd_snoop: assert property (
		wr_cmd && wdat == CMD_WR_OUTPUT |=> st_r == ST_WAIT_DATA)
		else $error("d1 command not caught");
	a_gate_set: assert property (
		wr_data && st_r == ST_WAIT_DATA
		|=> gate_r == $past(wb_dat_i[1]) && st_r == ST_IDLE)
		else $error("gate not updated on data write");
	a_warm_reset: assert property (
		cmd_pulse |=> rst_r [*2])
		else $error("warm reset pulse missing");
	a_status_read: assert property (
		rd_cap && hit_data && st_r == ST_SHOW_STATUS
		|=> wb_ack_o && wb_dat_o[1] == $past(gate_r)
		&& wb_dat_o[0] == $past(rst_r))
		else $error("status read wrong");
	a_sysctl_status: assert property (
		rd_cap && hit_sysctl |=> wb_dat_o[7:4] == $past(stat_s2_r))
		else $error("status bits wrong");
	a_sysctl_ctl: assert property (
		wr_sysctl |=> parity_check_disable == $past(wb_dat_i[2])
		&& speaker_enable == $past(wb_dat_i[1]))
		else $error("control bits not stored");
	a_gate_hold: assert property (
		wr_data && st_r != ST_WAIT_DATA |=> $stable(gate_r))
		else $error("stray data write moved gate");
	a_pend_clear: assert property (
		wr_cmd && wdat != CMD_WR_OUTPUT |=> st_r != ST_WAIT_DATA)
		else $error("pending command not cleared");
	// one ack per request, never two in a row
	a_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for two cycles");
	a_gate_event: assert property (
		wr_data && st_r == ST_WAIT_DATA && wdat[GATE_BIT] != gate_r
		|=> irq_stat_r[1])
		else $error("gate change not flagged");
	a_par_event: assert property (
		ev_par |=> irq_stat_r[2])
		else $error("parity event not flagged");
endmodule // kbe_top
`default_nettype wire

// [testbench/kbe_cpu_model.sv]
// Purpose: processor model issuing port cycles over classic Wishbone
// Assumes: one request at a time, byte data in bits 7:0
// Notes: a wait that runs out raises timed_out
`timescale 1ns/1ps
`default_nettype none
module kbe_cpu_model
(
	input wire logic core_clk,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	output logic wb_cyc_i,
	output logic wb_stb_i,
	output logic wb_we_i,
	output logic [31:0] wb_adr_i,
	output logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_i,
	output logic timed_out
);
	initial
	begin
		{wb_cyc_i, wb_stb_i, wb_we_i, timed_out} = 4'h0;
		wb_adr_i = 32'h0;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0;
	end
	// hold request until ack is sampled, then idle one cycle
	task automatic xfer(input logic we, input logic [9:0] adr,
		input logic [7:0] wd, output logic [7:0] rd);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {22'h0, adr};
		wb_dat_i <= {24'h0, wd};
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o[7:0];
		if (n >= 50)
			timed_out = 1'b1;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge core_clk);
	endtask
endmodule // kbe_cpu_model
`default_nettype wire

// [testbench/tb.sv]
// Purpose: self-checking bench for keyboard port emulation
// Assumes: 40 MHz clock, reset low for 2 cycles
// Notes: status pins moved with settle time for the two-stage sync
`timescale 1ns/1ps
`default_nettype none
module tb;
	import kbe_pkg::*;
	logic core_clk, nrst, cyc, stb, we, ack, timed_out;
	logic [31:0] adr, dout, din;
	logic [3:0] sel;
	kbe_stat_s stat;
	logic gate, wrst, chan, par, spk, tmr, irq;
	logic [7:0] rd;
	int err_total, compares;
	int rst_hi = 0;
	kbe_cpu_model kbe_cpu_model_i (.core_clk(core_clk), .wb_ack_o(ack),
		.wb_dat_o(dout), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(din),
		.timed_out(timed_out));
	kbe_top kbe_top_i (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(din), .wb_dat_o(dout), .wb_ack_o(ack), .stat_pins(stat),
		.addr_line20_gate(gate), .processor_warm_reset(wrst),
		.chan_check_disable(chan), .parity_check_disable(par),
		.speaker_enable(spk), .timer_ch2_gate(tmr), .irq(irq));
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// counts clock edges that see the warm reset high
	always @(posedge core_clk)
		if (wrst === 1'b1)
			rst_hi <= rst_hi + 1;
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] e, g);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("unexpected %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
		kbe_cpu_model_i.xfer(w, a, d, rd);
		if (timed_out)
		begin
			err_total++;
			conclude();
		end
	endtask
	task automatic t_reset();
		chk("ctl outs", 8'h0C, {4'h0, chan, par, spk, tmr});
		chk("gate,rst,irq", 8'h00, {5'h0, gate, wrst, irq});
		acc(1'b0, ADDR_SYSCTL, 8'h00);
		chk("sysctl", 8'hAC, rd);
		$display("t_reset done");
	endtask
	task automatic t_gate();
		acc(1'b1, ADDR_CMD, CMD_WR_OUTPUT);
		acc(1'b1, ADDR_DATA, 8'h02);
		chk("gate set", 8'h01, {7'h0, gate});
		acc(1'b1, ADDR_DATA, 8'h00);
		chk("stray data", 8'h01, {7'h0, gate});
		acc(1'b1, ADDR_CMD, CMD_WR_OUTPUT);
		acc(1'b1, ADDR_CMD, 8'hAA);
		acc(1'b1, ADDR_DATA, 8'h00);
		chk("cleared pend", 8'h01, {7'h0, gate});
		acc(1'b1, ADDR_CMD, CMD_RD_OUTPUT);
		acc(1'b0, ADDR_DATA, 8'h00);
		chk("status rd", 8'h02, rd);
		$display("t_gate done");
	endtask
	task automatic t_pulse();
		int n0;
		acc(1'b1, ADDR_IRQ_STAT, 8'h0F);
		acc(1'b1, ADDR_IRQ_MASK, 8'h01);
		chk("irq idle", 8'h00, {7'h0, irq});
		n0 = rst_hi;
		acc(1'b1, ADDR_CMD, CMD_PULSE_RST);
		chk("rst at once", 8'h01, {7'h0, wrst});
		repeat (12) @(posedge core_clk);
		chk("rst len", {4'h0, RST_PULSE_CYC}, 8'(rst_hi - n0));
		chk("irq raised", 8'h01, {7'h0, irq});
		acc(1'b1, ADDR_IRQ_STAT, 8'h01);
		chk("irq clear", 8'h00, {7'h0, irq});
		$display("t_pulse done");
	endtask
	task automatic t_irq();
		stat <= 4'h0;
		repeat (4) @(posedge core_clk);
		stat <= 4'hC;
		repeat (4) @(posedge core_clk);
		acc(1'b0, ADDR_IRQ_STAT, 8'h00);
		chk("check events", 8'h0C, rd);
		acc(1'b1, ADDR_IRQ_MASK, 8'h0C);
		chk("irq check", 8'h01, {7'h0, irq});
		acc(1'b0, ADDR_SYSCTL, 8'h00);
		chk("live status", 8'hC3, rd);
		acc(1'b1, ADDR_IRQ_STAT, 8'h0C);
		acc(1'b1, ADDR_SYSCTL, 8'h0F);
		stat <= 4'h0;
		repeat (4) @(posedge core_clk);
		stat <= 4'hC;
		repeat (4) @(posedge core_clk);
		acc(1'b0, ADDR_IRQ_STAT, 8'h00);
		chk("masked events", 8'h00, rd);
		chk("irq quiet", 8'h00, {7'h0, irq});
		$display("t_irq done");
	endtask
	task automatic t_ctl();
		acc(1'b1, ADDR_SYSCTL, 8'hF3);
		chk("ctl outs", 8'h03, {4'h0, chan, par, spk, tmr});
		acc(1'b0, ADDR_SYSCTL, 8'h00);
		chk("ro bits", 8'hA3, rd);
		acc(1'b0, 10'h3FC, 8'h00);
		chk("unmapped", 8'h00, rd);
		$display("t_ctl done");
	endtask
	initial
	begin
		err_total = 0;
		compares = 0;
		nrst = 1'b0;
		stat = 4'hA;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_gate();
		t_pulse();
		t_ctl();
		t_irq();
		conclude();
	end
endmodule // tb
`default_nettype wire
